//--- pos_cmd_model.sv
// pulse train source standing in for the external positioning controller
`timescale 1ns/1ps

module pos_cmd_model (
    // clock
    input wire logic i_clk,
    // pulse train
    output logic o_pulse,
    output logic o_dir
);
    initial begin
        o_pulse = 1'b0;
        o_dir = 1'b0;
    end

    // gap 0 gives one pulse every cycle; dir goes inverse once released
    task automatic send(input int n, input logic d, input int gap);
        repeat (n) begin
            @(posedge i_clk);
            o_pulse <= 1'b1;
            o_dir <= d;
            repeat (gap) begin
                @(posedge i_clk);
                o_pulse <= 1'b0;
                o_dir <= ~d;
            end
        end
        @(posedge i_clk);
        o_pulse <= 1'b0;
        o_dir <= ~d;
    endtask
endmodule

//--- pos_mode_pkg.sv
// types for the position mode block
package pos_mode_pkg;

    typedef enum logic [2:0] {
        MODE_SPEED,
        MODE_TORQUE,
        MODE_POSITION,
        MODE_TEST,
        MODE_VF
    } ctrl_mode_t;

    typedef struct packed {
        logic [1:0] rst_sync;
        logic [4:0] method;
        logic [1:0] source;
        logic [14:0] inpos_width;
        logic [13:0] excess;
        logic [13:0] mon_sel;
        logic clear_sel;
        logic panel;
        logic signed [31:0] cmd_cnt;
        logic signed [31:0] fb_cnt;
        logic signed [31:0] droop;
        logic dev_clr_prev;
        logic in_pos;
        logic fault;
        logic fwd_end;
        logic rev_end;
        logic fwd_run;
        logic rev_run;
        logic [31:0] mon_value;
        logic ack;
        logic [31:0] rdata;
    } state_t;

endpackage

//--- pos_mode_regs.svh
// register offsets, field positions, reset values and constants for the position mode block
`ifndef POS_MODE_REGS_SVH
`define POS_MODE_REGS_SVH

// ----------------------------------------------------------------
// register byte offsets
// ----------------------------------------------------------------
`define OFS_METHOD 6'h00
`define OFS_SOURCE 6'h04
`define OFS_INPOS_WIDTH 6'h08
`define OFS_EXCESS 6'h0c
`define OFS_MON_SEL 6'h10
`define OFS_CLEAR_SEL 6'h14
`define OFS_PANEL 6'h18
`define OFS_STATUS 6'h1c
`define OFS_MON_VALUE 6'h20
`define OFS_CMD_COUNT 6'h24
`define OFS_FB_COUNT 6'h28
`define OFS_DROOP 6'h2c

// ----------------------------------------------------------------
// reset values
// ----------------------------------------------------------------
`define RST_METHOD 5'h14
`define RST_SOURCE 2'h0
`define RST_INPOS_WIDTH 15'h0064
`define RST_EXCESS 14'h0028
`define RST_MON_SEL 14'h270f
`define RST_CLEAR_SEL 1'h1
`define RST_PANEL 1'h0

// ----------------------------------------------------------------
// constants
// ----------------------------------------------------------------
`define EXCESS_OFF 14'h270f
`define EXCESS_UNIT 32'h000003e8
`define EXCESS_MAX 14'h0190
`define MON_FREQ 14'h270f
`define SPLIT_BUILTIN 32'h00002710
`define SPLIT_EXTERNAL 32'h000186a0

// status register bit positions
`define ST_INPOS 0
`define ST_FAULT 1
`define ST_MODE_LSB 2
`define ST_FWD_END 5
`define ST_REV_END 6
`define ST_SERVO 7

`endif

//--- pos_mode_select.sv
// control-mode selection, terminal remap and droop supervision with register slave
//
// Our own choices: the register offsets and register access over Avalon-MM.
`timescale 1ns/1ps
`include "pos_mode_regs.svh"

module pos_mode_select
    import pos_mode_pkg::*;
(
    // clock and reset
    input wire logic i_ref_clk,
    input wire logic i_nrst,
    // avalon-mm slave
    input wire logic [5:0] i_avs_address,
    input wire logic i_avs_read,
    input wire logic i_avs_write,
    input wire logic [31:0] i_avs_writedata,
    input wire logic [3:0] i_avs_byteenable,
    output logic [31:0] o_avs_readdata,
    output logic o_avs_waitrequest,
    // drive terminals
    input wire logic i_mode_switch_input,
    input wire logic i_forward_input,
    input wire logic i_reverse_input,
    input wire logic i_servo_on,
    input wire logic i_base_shutoff,
    input wire logic i_pulse_clear_input,
    input wire logic i_deviation_clear_input,
    // position command pulses per source, already scaled
    input wire logic i_param_cmd_pulse,
    input wire logic i_param_cmd_dir,
    input wire logic i_option_cmd_pulse,
    input wire logic i_option_cmd_dir,
    input wire logic i_own_cmd_pulse,
    input wire logic i_own_cmd_dir,
    // encoder feedback pulses
    input wire logic i_fb_pulse,
    input wire logic i_fb_dir,
    // frequency monitor value
    input wire logic [31:0] i_freq_monitor,
    // mode and terminal outputs
    output ctrl_mode_t o_ctrl_mode,
    output logic o_sensorless,
    output logic o_fwd_stroke_end,
    output logic o_rev_stroke_end,
    output logic o_fwd_rotation_cmd,
    output logic o_rev_rotation_cmd,
    // supervision outputs
    output logic o_in_position_output,
    output logic o_position_error_fault,
    output logic [31:0] o_monitor_value
);

    // ----------------------------------------------------------------
    // reset synchroniser
    // ----------------------------------------------------------------
    logic [1:0] rst_pipe_r;
    logic rst_n;

    always_ff @(posedge i_ref_clk or negedge i_nrst) begin
        if (!i_nrst) begin
            rst_pipe_r <= 2'h0;
        end else begin
            rst_pipe_r <= {rst_pipe_r[0], 1'h1};
        end
    end
    assign rst_n = rst_pipe_r[1];

    // ----------------------------------------------------------------
    // helpers
    // ----------------------------------------------------------------
    function automatic logic [31:0] merge(input logic [31:0] old, input logic [31:0] wd,
                                          input logic [3:0] be);
        logic [31:0] res;
        res = old;
        for (int b = 0; b < 4; b++) begin
            if (be[b]) begin
                res[b*8 +: 8] = wd[b*8 +: 8];
            end
        end
        return res;
    endfunction

    function automatic logic legal_method(input logic [31:0] v);
        return (v <= 32'h5) || (v >= 32'h9 && v <= 32'hc) || (v == 32'h14);
    endfunction

    function automatic logic [31:0] mag(input logic signed [31:0] v);
        return v[31] ? 32'(-v) : 32'(v);
    endfunction

    // ----------------------------------------------------------------
    // state
    // ----------------------------------------------------------------
    state_t st_r;
    state_t st_nxt;

    ctrl_mode_t mode;
    logic sensorless;
    logic req;
    logic wr_go;
    logic cmd_pulse;
    logic cmd_dir;
    logic signed [31:0] cmd_step;
    logic signed [31:0] fb_step;
    logic [31:0] droop_mag;
    logic [31:0] excess_thr;
    logic [31:0] split;
    logic [31:0] mon_src;
    logic [31:0] wmerged;
    logic [31:0] rd_value;
    logic [7:0] status;

    // ----------------------------------------------------------------
    // control method decode
    // ----------------------------------------------------------------
    always_comb begin
        sensorless = 1'b0;
        unique case (st_r.method)
            5'd0: mode = MODE_SPEED;
            5'd1: mode = MODE_TORQUE;
            5'd2: mode = i_mode_switch_input ? MODE_TORQUE : MODE_SPEED;
            5'd3: mode = MODE_POSITION;
            5'd4: mode = i_mode_switch_input ? MODE_POSITION : MODE_SPEED;
            5'd5: mode = i_mode_switch_input ? MODE_TORQUE : MODE_POSITION;
            5'd9: mode = MODE_TEST;
            5'd10: begin
                mode = MODE_SPEED;
                sensorless = 1'b1;
            end
            5'd11: begin
                mode = MODE_TORQUE;
                sensorless = 1'b1;
            end
            5'd12: begin
                mode = i_mode_switch_input ? MODE_TORQUE : MODE_SPEED;
                sensorless = 1'b1;
            end
            // writes filter illegal codes, so only 20 lands here
            default: mode = MODE_VF;
        endcase
    end

    // ----------------------------------------------------------------
    // pulse selection and droop arithmetic
    // ----------------------------------------------------------------
    always_comb begin
        unique case (st_r.source)
            2'd1: begin
                cmd_pulse = i_option_cmd_pulse;
                cmd_dir = i_option_cmd_dir;
            end
            2'd2: begin
                cmd_pulse = i_own_cmd_pulse;
                cmd_dir = i_own_cmd_dir;
            end
            default: begin
                cmd_pulse = i_param_cmd_pulse;
                cmd_dir = i_param_cmd_dir;
            end
        endcase
        // only position states consume commands; the source mux still shows them
        if (cmd_pulse && mode == MODE_POSITION) begin
            cmd_step = cmd_dir ? -32'sd1 : 32'sd1;
        end else begin
            cmd_step = 32'sd0;
        end
        fb_step = i_fb_pulse ? (i_fb_dir ? -32'sd1 : 32'sd1) : 32'sd0;
        droop_mag = mag(st_r.droop);
        excess_thr = 32'(st_r.excess) * `EXCESS_UNIT;
        split = st_r.panel ? `SPLIT_EXTERNAL : `SPLIT_BUILTIN;
        unique case (st_r.mon_sel[2:1])
            2'd0: mon_src = mag(st_r.cmd_cnt);
            2'd1: mon_src = mag(st_r.fb_cnt);
            default: mon_src = droop_mag;
        endcase
    end

    // ----------------------------------------------------------------
    // register read mux
    // ----------------------------------------------------------------
    assign req = i_avs_read | i_avs_write;
    assign wr_go = i_avs_write & st_r.ack;
    assign status = {i_servo_on, st_r.rev_end, st_r.fwd_end, mode, st_r.fault, st_r.in_pos};

    always_comb begin
        unique case (i_avs_address)
            `OFS_METHOD: rd_value = {27'h0, st_r.method};
            `OFS_SOURCE: rd_value = {30'h0, st_r.source};
            `OFS_INPOS_WIDTH: rd_value = {17'h0, st_r.inpos_width};
            `OFS_EXCESS: rd_value = {18'h0, st_r.excess};
            `OFS_MON_SEL: rd_value = {18'h0, st_r.mon_sel};
            `OFS_CLEAR_SEL: rd_value = {31'h0, st_r.clear_sel};
            `OFS_PANEL: rd_value = {31'h0, st_r.panel};
            `OFS_STATUS: rd_value = {24'h0, status};
            `OFS_MON_VALUE: rd_value = st_r.mon_value;
            `OFS_CMD_COUNT: rd_value = st_r.cmd_cnt;
            `OFS_FB_COUNT: rd_value = st_r.fb_cnt;
            `OFS_DROOP: rd_value = st_r.droop;
            default: rd_value = 32'h0;
        endcase
        wmerged = merge(rd_value, i_avs_writedata, i_avs_byteenable);
    end

    // ----------------------------------------------------------------
    // next state
    // ----------------------------------------------------------------
    always_comb begin
        st_nxt = st_r;
        st_nxt.rst_sync = {st_r.rst_sync[0], rst_n};

        // bus: one wait cycle, read data loaded while waiting
        st_nxt.ack = req & ~st_r.ack;
        if (req && !st_r.ack) begin
            st_nxt.rdata = rd_value;
        end
        if (wr_go) begin
            unique case (i_avs_address)
                `OFS_METHOD: begin
                    if (legal_method(wmerged)) begin
                        st_nxt.method = wmerged[4:0];
                    end
                end
                `OFS_SOURCE: begin
                    if (wmerged <= 32'h2) begin
                        st_nxt.source = wmerged[1:0];
                    end
                end
                `OFS_INPOS_WIDTH: st_nxt.inpos_width = wmerged[14:0];
                `OFS_EXCESS: begin
                    if (wmerged <= 32'(`EXCESS_MAX) || wmerged == 32'(`EXCESS_OFF)) begin
                        st_nxt.excess = wmerged[13:0];
                    end
                end
                `OFS_MON_SEL: begin
                    if (wmerged <= 32'h5 || wmerged == 32'(`MON_FREQ)) begin
                        st_nxt.mon_sel = wmerged[13:0];
                    end
                end
                `OFS_CLEAR_SEL: st_nxt.clear_sel = wmerged[0];
                `OFS_PANEL: st_nxt.panel = wmerged[0];
                default: begin
                end
            endcase
        end

        // cumulative counts
        if (i_base_shutoff || i_pulse_clear_input) begin
            st_nxt.cmd_cnt = 32'sd0;
            st_nxt.fb_cnt = 32'sd0;
        end else if (i_servo_on) begin
            st_nxt.cmd_cnt = st_r.cmd_cnt + cmd_step;
            st_nxt.fb_cnt = st_r.fb_cnt + fb_step;
        end

        // droop: cleared outside servo on and by the deviation clear input
        st_nxt.dev_clr_prev = i_deviation_clear_input;
        if (!i_servo_on || i_base_shutoff) begin
            st_nxt.droop = 32'sd0;
        end else if (!st_r.clear_sel && i_deviation_clear_input && !st_r.dev_clr_prev) begin
            st_nxt.droop = 32'sd0;
        end else if (st_r.clear_sel && i_deviation_clear_input) begin
            st_nxt.droop = 32'sd0;
        end else begin
            st_nxt.droop = st_r.droop + cmd_step - fb_step;
        end

        // supervision
        st_nxt.in_pos = (mode == MODE_POSITION) && (droop_mag < 32'(st_r.inpos_width));
        // fault latches until the base is shut off; a new excess wins over the clear
        if (mode == MODE_POSITION && st_r.excess != `EXCESS_OFF
                && droop_mag > excess_thr) begin
            st_nxt.fault = 1'b1;
        end else if (i_base_shutoff) begin
            st_nxt.fault = 1'b0;
        end

        // terminal remap
        if (mode == MODE_POSITION) begin
            st_nxt.fwd_end = i_forward_input;
            st_nxt.rev_end = i_reverse_input;
            st_nxt.fwd_run = 1'b0;
            st_nxt.rev_run = 1'b0;
        end else begin
            st_nxt.fwd_end = 1'b0;
            st_nxt.rev_end = 1'b0;
            st_nxt.fwd_run = i_forward_input;
            st_nxt.rev_run = i_reverse_input;
        end

        // monitor: 9999 takes the frequency input; other codes: even codes lower part, odd codes upper part
        if (st_r.mon_sel == `MON_FREQ) begin
            st_nxt.mon_value = i_freq_monitor;
        end else if (st_r.mon_sel[0]) begin
            st_nxt.mon_value = (mon_src / split) % split;
        end else begin
            st_nxt.mon_value = mon_src % split;
        end
    end

    always_ff @(posedge i_ref_clk or negedge rst_n) begin
        if (!rst_n) begin
            st_r <= '0;
            st_r.method <= `RST_METHOD;
            st_r.source <= `RST_SOURCE;
            st_r.inpos_width <= `RST_INPOS_WIDTH;
            st_r.excess <= `RST_EXCESS;
            st_r.mon_sel <= `RST_MON_SEL;
            st_r.clear_sel <= `RST_CLEAR_SEL;
            st_r.panel <= `RST_PANEL;
        end else begin
            st_r <= st_nxt;
        end
    end

    // ----------------------------------------------------------------
    // outputs
    // ----------------------------------------------------------------
    assign o_avs_waitrequest = req & ~st_r.ack;
    assign o_avs_readdata = st_r.rdata;
    assign o_ctrl_mode = mode;
    assign o_sensorless = sensorless;
    assign o_fwd_stroke_end = st_r.fwd_end;
    assign o_rev_stroke_end = st_r.rev_end;
    assign o_fwd_rotation_cmd = st_r.fwd_run;
    assign o_rev_rotation_cmd = st_r.rev_run;
    assign o_in_position_output = st_r.in_pos;
    assign o_position_error_fault = st_r.fault;
    assign o_monitor_value = st_r.mon_value;

endmodule

//--- pos_mode_select_assertions.sv
// concurrent checks on the mode selection and droop supervision ports
`timescale 1ns/1ps

module pos_mode_select_checker
    import pos_mode_pkg::*;
(
    // clock and reset
    input wire logic i_ref_clk,
    input wire logic i_nrst,
    // bus handshake
    input wire logic i_avs_read,
    input wire logic i_avs_write,
    input wire logic o_avs_waitrequest,
    // terminals
    input wire logic i_forward_input,
    input wire logic i_reverse_input,
    input wire logic i_base_shutoff,
    // outputs under watch
    input wire ctrl_mode_t o_ctrl_mode,
    input wire logic o_sensorless,
    input wire logic o_fwd_stroke_end,
    input wire logic o_rev_stroke_end,
    input wire logic o_fwd_rotation_cmd,
    input wire logic o_rev_rotation_cmd,
    input wire logic o_in_position_output,
    input wire logic o_position_error_fault
);
    // ------------------------------------------------
    // helpers
    // ------------------------------------------------
    logic req;
    logic pos;
    assign req = i_avs_read | i_avs_write;
    assign pos = (o_ctrl_mode == MODE_POSITION);

    // checks wait one edge past the design's own reset copy, which lifts two edges late
    logic [2:0] live_r;
    always_ff @(posedge i_ref_clk or negedge i_nrst) begin
        if (!i_nrst) begin
            live_r <= 3'h0;
        end else begin
            live_r <= {live_r[1:0], 1'b1};
        end
    end

    default clocking @(posedge i_ref_clk); endclocking
    default disable iff (!live_r[2]);

    // ------------------------------------------------
    // assertions
    // ------------------------------------------------
    a_wait_once: assert property (req && o_avs_waitrequest |=> !o_avs_waitrequest)
        else $error("waitrequest held longer than one cycle");
    a_wait_idle: assert property (!req |-> !o_avs_waitrequest)
        else $error("waitrequest without a request");
    a_stroke_map: assert property ({o_fwd_stroke_end, o_rev_stroke_end} ==
        $past({i_forward_input, i_reverse_input} & {2{pos}}))
        else $error("stroke end outputs wrong");
    a_rotation_map: assert property ({o_fwd_rotation_cmd, o_rev_rotation_cmd} ==
        $past({i_forward_input, i_reverse_input} & {2{!pos}}))
        else $error("rotation outputs wrong");
    a_map_exclusive: assert property (!((o_fwd_stroke_end | o_rev_stroke_end) &&
        (o_fwd_rotation_cmd | o_rev_rotation_cmd)))
        else $error("stroke and rotation active together");
    a_inpos_mode: assert property (o_in_position_output |-> $past(pos))
        else $error("in-position outside position mode");
    a_fault_mode: assert property ($rose(o_position_error_fault) |-> $past(pos))
        else $error("fault raised outside position mode");
    a_fault_sticky: assert property (o_position_error_fault && !i_base_shutoff
        |=> o_position_error_fault)
        else $error("fault dropped without base shutoff");
    a_fault_clear: assert property (i_base_shutoff [*3] |-> !o_position_error_fault)
        else $error("fault not cleared by base shutoff");
    a_sensorless_mode: assert property (o_sensorless |->
        o_ctrl_mode inside {MODE_SPEED, MODE_TORQUE})
        else $error("sensorless flag with wrong mode");

    c_stroke: cover property (pos && o_fwd_stroke_end);
    c_rotation: cover property (o_fwd_rotation_cmd);
    c_inpos: cover property (o_in_position_output);
    c_fault: cover property (o_position_error_fault);
endmodule

bind pos_mode_select pos_mode_select_checker u_pos_mode_select_checker (
    .i_ref_clk, .i_nrst, .i_avs_read, .i_avs_write, .o_avs_waitrequest,
    .i_forward_input, .i_reverse_input, .i_base_shutoff, .o_ctrl_mode,
    .o_sensorless, .o_fwd_stroke_end, .o_rev_stroke_end, .o_fwd_rotation_cmd,
    .o_rev_rotation_cmd, .o_in_position_output, .o_position_error_fault
);

//--- pos_mode_select_tb.sv
// self-checking bench for mode selection and droop supervision
`timescale 1ns/1ps
`include "pos_mode_regs.svh"

module pos_mode_select_tb
    import pos_mode_pkg::*;
;
    logic clk = 1'b0, nrst = 1'b0, rd_r = 1'b0, wr_r = 1'b0, wait_r;
    logic [5:0] adr = 6'h00;
    logic [31:0] wd = 32'h0, rdat, mon, freq = 32'h0000abcd;
    logic sw = 1'b0, fwd = 1'b1, rev = 1'b0, servo = 1'b0, bso = 1'b0;
    logic pclr = 1'b0, dclr = 1'b0, sens, fs, rs, fr, rr, inpos, flt;
    logic pp, pd, op, od, wp, wdir, fp, fd;
    ctrl_mode_t mode;
    int n_mismatch = 0, num_checks = 0;
    int mlist[10] = '{0, 1, 2, 3, 4, 5, 9, 10, 11, 12};
    int src_exp[3] = '{2, 5, 3};
    int mon_exp[2][6] = '{'{2345, 1, 7, 0, 2338, 1}, '{12345, 0, 7, 0, 12338, 0}};

    always #5 clk = ~clk;

    pos_mode_select u_pos_mode_select (.i_ref_clk(clk), .i_nrst(nrst),
        .i_avs_address(adr), .i_avs_read(rd_r), .i_avs_write(wr_r),
        .i_avs_writedata(wd), .i_avs_byteenable(4'hf), .o_avs_readdata(rdat),
        .o_avs_waitrequest(wait_r), .i_mode_switch_input(sw), .i_forward_input(fwd),
        .i_reverse_input(rev), .i_servo_on(servo), .i_base_shutoff(bso),
        .i_pulse_clear_input(pclr), .i_deviation_clear_input(dclr),
        .i_param_cmd_pulse(pp), .i_param_cmd_dir(pd), .i_option_cmd_pulse(op),
        .i_option_cmd_dir(od), .i_own_cmd_pulse(wp), .i_own_cmd_dir(wdir),
        .i_fb_pulse(fp), .i_fb_dir(fd), .i_freq_monitor(freq), .o_ctrl_mode(mode),
        .o_sensorless(sens), .o_fwd_stroke_end(fs), .o_rev_stroke_end(rs),
        .o_fwd_rotation_cmd(fr), .o_rev_rotation_cmd(rr),
        .o_in_position_output(inpos), .o_position_error_fault(flt),
        .o_monitor_value(mon));

    // one pulse source per command path, one for the encoder
    pos_cmd_model u_opt (.i_clk(clk), .o_pulse(op), .o_dir(od));
    pos_cmd_model u_par (.i_clk(clk), .o_pulse(pp), .o_dir(pd));
    pos_cmd_model u_own (.i_clk(clk), .o_pulse(wp), .o_dir(wdir));
    pos_cmd_model u_fb (.i_clk(clk), .o_pulse(fp), .o_dir(fd));

    // ------------------------------------------------
    // tasks
    // ------------------------------------------------
    task automatic chk(input logic [31:0] g, input logic [31:0] e);
        num_checks++;
        if (g !== e) begin
            n_mismatch++;
            $display("BAD %0t got %h exp %h", $time, g, e);
        end
    endtask

    // request held until waitrequest is seen low at a rising edge
    task automatic bus(input logic w, input logic [5:0] a, input logic [31:0] d,
                       output logic [31:0] q);
        int n;
        logic busy;
        n = 0;
        busy = 1'b1;
        q = 32'h0;
        @(posedge clk);
        rd_r <= !w;
        wr_r <= w;
        adr <= a;
        wd <= d;
        do begin
            // settled values, the same that the next rising edge samples
            @(negedge clk);
            busy = (wait_r !== 1'b0);
            q = rdat;
            @(posedge clk);
            n++;
        end while (busy && n < 50);
        if (busy) chk(32'h1, 32'h0);
        rd_r <= 1'b0;
        wr_r <= 1'b0;
    endtask

    task automatic wr(input logic [5:0] a, input logic [31:0] d);
        logic [31:0] q;
        bus(1'b1, a, d, q);
    endtask

    task automatic rd(input logic [5:0] a, input logic [31:0] e);
        logic [31:0] q;
        bus(1'b0, a, 32'h0, q);
        chk(q, e);
    endtask

    task automatic tick(input int n);
        repeat (n) @(posedge clk);
    endtask

    task automatic shut_base();
        bso <= 1'b1;
        tick(3);
        bso <= 1'b0;
    endtask

    function automatic ctrl_mode_t exp_mode(input int m, input logic s);
        case (m)
            0, 10: return MODE_SPEED;
            1, 11: return MODE_TORQUE;
            2, 12: return s ? MODE_TORQUE : MODE_SPEED;
            3: return MODE_POSITION;
            4: return s ? MODE_POSITION : MODE_SPEED;
            5: return s ? MODE_TORQUE : MODE_POSITION;
            9: return MODE_TEST;
            default: return MODE_VF;
        endcase
    endfunction

    task automatic give_verdict();
        $display("checks %0d mismatches %0d", num_checks, n_mismatch);
        if (n_mismatch == 0 && num_checks > 0)
            $display("ALL TESTS PASSED");
        else
            $display("TESTS FAILED");
        $finish;
    endtask

    // ------------------------------------------------
    // tests
    // ------------------------------------------------
    initial begin
        #600000;
        n_mismatch++;
        give_verdict();
    end

    initial begin
        tick(12);
        nrst <= 1'b1;
        tick(3);
        rd(`OFS_METHOD, 32'd20);
        chk(32'(mode), 32'(MODE_VF));
        rd(`OFS_SOURCE, 32'd0);
        chk(mon, freq);
        rd(6'h30, 32'h0);
        foreach (mlist[i]) begin
            for (int s = 0; s < 2; s++) begin
                sw <= s[0];
                fwd <= !s[0];
                rev <= s[0];
                wr(`OFS_METHOD, mlist[i]);
                tick(2);
                chk(32'(mode), 32'(exp_mode(mlist[i], s[0])));
                chk(32'(sens), 32'(mlist[i] >= 10));
                chk({fs, rs, fr, rr},
                    (exp_mode(mlist[i], s[0]) == MODE_POSITION) ? (32'h8 >> s) : (32'h2 >> s));
            end
        end
        wr(`OFS_METHOD, 32'd6);
        rd(`OFS_METHOD, 32'd12);
        wr(`OFS_METHOD, 32'd3);
        wr(`OFS_EXCESS, 32'd9999);
        wr(`OFS_INPOS_WIDTH, 32'd3);
        u_par.send(4, 1'b0, 0);
        rd(`OFS_CMD_COUNT, 32'd0);
        servo <= 1'b1;
        for (int s = 0; s < 3; s++) begin
            wr(`OFS_SOURCE, s);
            pclr <= 1'b1;
            tick(2);
            pclr <= 1'b0;
            fork
                u_par.send(2, 1'b0, 1);
                u_opt.send(5, 1'b0, 0);
                u_own.send(3, 1'b0, 2);
            join
            rd(`OFS_CMD_COUNT, src_exp[s]);
        end
        shut_base();
        rd(`OFS_CMD_COUNT, 32'd0);
        rd(`OFS_DROOP, 32'd0);
        wr(`OFS_SOURCE, 32'd1);
        u_opt.send(2, 1'b0, 1);
        tick(3);
        chk(inpos, 1'b1);
        rd(`OFS_STATUS, 32'h000000c9);
        u_opt.send(1, 1'b0, 0);
        tick(3);
        chk(inpos, 1'b0);
        u_fb.send(5, 1'b0, 0);
        rd(`OFS_DROOP, 32'hfffffffe);
        rd(`OFS_FB_COUNT, 32'd5);
        chk(inpos, 1'b1);
        wr(`OFS_EXCESS, 32'd0);
        tick(3);
        chk(flt, 1'b1);
        wr(`OFS_EXCESS, 32'd9999);
        shut_base();
        u_opt.send(3, 1'b0, 0);
        tick(3);
        chk(flt, 1'b0);
        shut_base();
        u_opt.send(12345, 1'b0, 0);
        u_fb.send(7, 1'b0, 0);
        for (int p = 0; p < 2; p++) begin
            wr(`OFS_PANEL, p);
            for (int k = 0; k < 6; k++) begin
                wr(`OFS_MON_SEL, k);
                tick(3);
                chk(mon, mon_exp[p][k]);
            end
        end
        wr(`OFS_MON_SEL, 32'd9999);
        tick(3);
        chk(mon, freq);
        dclr <= 1'b1;
        u_opt.send(1, 1'b0, 0);
        rd(`OFS_DROOP, 32'd0);
        dclr <= 1'b0;
        u_opt.send(2, 1'b0, 0);
        wr(`OFS_CLEAR_SEL, 32'd0);
        dclr <= 1'b1;
        tick(3);
        rd(`OFS_DROOP, 32'd0);
        u_opt.send(1, 1'b0, 0);
        rd(`OFS_DROOP, 32'd1);
        dclr <= 1'b0;
        give_verdict();
    end
endmodule
